// >>> include/lsc_pkg.sv
// shared constants of the lamp switch control pins
package lsc_pkg;
    localparam int          LSC_CLK_HZ        = 50_000_000;
    localparam int          LSC_CLK_NS        = 1_000_000_000 / LSC_CLK_HZ;
    localparam int          LSC_NCH           = 4;
    localparam int          LSC_WORD_BITS     = 16;
    // host timing, printed figures
    localparam int          LSC_RST_LOW_NS    = 10_000;
    localparam int          LSC_RST_TO_CS_NS  = 5_000;
    localparam int          LSC_SPI_MAX_KHZ   = 8_000;
    localparam int          LSC_RST_LOW_CYC   = (LSC_RST_LOW_NS + LSC_CLK_NS - 1) / LSC_CLK_NS;
    localparam int          LSC_RST_TO_CS_CYC = (LSC_RST_TO_CS_NS + LSC_CLK_NS - 1) / LSC_CLK_NS;
    // half period of serial clock, rounded up so the rate stays at or below the limit
    localparam int          LSC_SCK_HALF_CYC  = (LSC_CLK_HZ / 1000 + 2 * LSC_SPI_MAX_KHZ - 1) / (2 * LSC_SPI_MAX_KHZ);
    // serial word: [15:12] address, [11:0] data
    localparam int          LSC_ADDR_MSB      = 15;
    localparam int          LSC_ADDR_LSB      = 12;
    localparam logic [3:0]  LSC_A_CTRL        = 4'h1;
    localparam logic [3:0]  LSC_A_DUTY        = 4'h2;
    localparam logic [3:0]  LSC_A_SENSE       = 4'h3;
    localparam logic [3:0]  LSC_A_FAULT       = 4'h4;
    // ctrl fields
    localparam int          LSC_CTRL_DIM_EN   = 0;
    localparam int          LSC_CTRL_CLK_SEL  = 1;
    localparam logic [11:0] LSC_CTRL_RST      = 12'h000;
    // sense fields: [1:0] channel, [2] temperature, [3] tri-state
    localparam int          LSC_SNS_TEMP      = 2;
    localparam int          LSC_SNS_HIZ       = 3;
    localparam logic [11:0] LSC_SNS_RST       = 12'h008;
    localparam logic [7:0]  LSC_DUTY_RST      = 8'h00;
    localparam logic [7:0]  LSC_DUTY_FULL     = 8'hFF;
    localparam int          LSC_DIM_CLK_TIMEOUT = 4096;
    // host register bus offsets
    localparam logic [3:0]  LSC_R_CMD         = 4'h0;
    localparam logic [3:0]  LSC_R_RX          = 4'h4;
    localparam logic [3:0]  LSC_R_PINS        = 4'h8;
    localparam logic [3:0]  LSC_R_IRQ_STAT    = 4'hC;
    localparam logic [3:0]  LSC_R_IRQ_CLR     = 4'hC;
    localparam logic [3:0]  LSC_R_IRQ_EN      = 4'h0;
    localparam int          LSC_EV_DONE       = 0;
    localparam int          LSC_EV_FAULT      = 1;
endpackage

// >>> include/lsc_if.sv
// pins between lamp switch and host
interface lsc_if;
    logic       rst_n;
    logic       wake;
    logic [3:0] direct_ctl;
    logic       cs_n;
    logic       sclk;
    logic       si;
    logic       so;
    logic       so_oe_n;
    logic       fault_flag_n_oe_n;
    logic       sense_hiz;
    logic       sense_temp;
    logic [1:0] sense_ch;
    modport dev  (input rst_n, wake, direct_ctl, cs_n, sclk, si,
                  output so, so_oe_n, fault_flag_n_oe_n, sense_hiz, sense_temp, sense_ch);
    modport host (output rst_n, wake, direct_ctl, cs_n, sclk, si,
                  input so, so_oe_n, fault_flag_n_oe_n, sense_hiz, sense_temp, sense_ch);
endinterface

// >>> core/lsc_dimmer.sv
// one dimming channel: duty ramp with full on and full off
module lsc_dimmer
    import lsc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic [7:0] duty_i,
    output logic            on_o
);
    logic [7:0] phase;
    logic [7:0] next_phase;
    logic       next_on;

    always_comb begin
        next_phase = tick_i ? phase + 8'h01 : phase;
        if (duty_i == LSC_DUTY_FULL) begin
            next_on = 1'b1;
        end else begin
            next_on = (phase < duty_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= 8'h00;
            on_o  <= 1'b0;
        end else begin
            phase <= next_phase;
            on_o  <= next_on;
        end
    end
endmodule // lsc_dimmer

// >>> core/lsc_device.sv
// device end: wake, reset, direct control, dimming, fault pin, serial slave
// Behaviour
// - clock watchdog only when dimming on, external
// - duty full gives always on, zero off
// - serial setting picks current or temperature sense
// - serial command tri-states the sense output
// - any direct input wakes from sleep
// - direct input drives its own power output while dimming is off
// - host gives dimming clock on direct input zero
// - fault pulls fault pin low; detail over serial
// - wake input leaves sleep too
// - reset low wakes, clears registers, enters sleep
// - reset rising edge starts the watchdog
// - host holds reset low ten microseconds
// - host waits five microseconds before select
// - host serial clock at most eight megahertz
// - sixteen bits, msb first, sampled falling edge
// - select rising edge loads addressed register
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
module lsc_device
    import lsc_pkg::*;
#(
    parameter int WDOG_CYC = 1_000_000,
    parameter int CLK_TIMEOUT = LSC_DIM_CLK_TIMEOUT
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    lsc_if.dev                    pins,
    input  wire logic [3:0]       hw_fault_i,
    output logic      [3:0]       power_switch_out_o,
    output logic                  awake_o,
    output logic                  wdog_run_o,
    output logic                  wdog_expired_o,
    output logic                  dim_clk_fail_o
);
    if (WDOG_CYC < 2 || CLK_TIMEOUT < 2) begin : g_bad_cnt
        $error("lsc_device: counts too small");
    end

    typedef enum logic [1:0] {
        LSC_SLEEP = 2'b01,
        LSC_AWAKE = 2'b10
    } lsc_mode_t;

    lsc_mode_t   mode, next_mode;
    logic [11:0] ctrl, next_ctrl;
    logic [11:0] sense, next_sense;
    logic [7:0]  duty [LSC_NCH];
    logic [7:0]  next_duty [LSC_NCH];
    logic [15:0] shreg, next_shreg;
    logic [15:0] txreg, next_txreg;
    logic [3:0]  flt, next_flt;
    logic        cs_q, sck_q, in0_q, rstn_q;
    logic        next_cs_q, next_sck_q, next_in0_q, next_rstn_q;
    logic [31:0] wdog, next_wdog;
    logic        wdog_run, next_wdog_run, next_wexp;
    logic [31:0] clkmon, next_clkmon;
    logic        next_clkfail;
    logic        so_bit, next_so_bit;
    logic [3:0]  dim_on;
    logic        dim_tick;
    logic        wake_req;

    wire cs_rise   = pins.cs_n & ~cs_q;
    wire cs_fall   = ~pins.cs_n & cs_q;
    wire sck_fall  = ~pins.sclk & sck_q;
    wire sck_rise  = pins.sclk & ~sck_q;
    wire clk_check = ctrl[LSC_CTRL_DIM_EN] & ~ctrl[LSC_CTRL_CLK_SEL];
    assign dim_tick = ctrl[LSC_CTRL_CLK_SEL] ? 1'b1 : (pins.direct_ctl[0] & ~in0_q);

    assign wake_req = ~pins.rst_n | pins.wake | (|pins.direct_ctl);

    genvar g;
    generate
        for (g = 0; g < LSC_NCH; g++) begin : g_dim
            lsc_dimmer u_dim (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .tick_i (dim_tick),
                .duty_i (duty[g]),
                .on_o   (dim_on[g])
            );
        end
    endgenerate

    always_comb begin
        next_mode    = mode;
        next_ctrl    = ctrl;
        next_sense   = sense;
        next_duty    = duty;
        next_shreg   = shreg;
        next_txreg   = txreg;
        next_so_bit  = so_bit;
        next_cs_q    = pins.cs_n;
        next_sck_q   = pins.sclk;
        next_in0_q   = pins.direct_ctl[0];
        next_rstn_q  = pins.rst_n;
        next_flt     = hw_fault_i | (flt & {4{mode == LSC_AWAKE}});
        next_wdog_run = wdog_run;
        next_wdog    = wdog;
        next_wexp    = wdog_expired_o;
        next_clkmon  = clkmon;
        next_clkfail = dim_clk_fail_o;
        if (mode == LSC_SLEEP && wake_req && pins.rst_n) begin
            next_mode = LSC_AWAKE;
        end
        if (cs_fall) begin
            next_txreg  = {4'h0, 8'h00, flt};
            next_shreg  = 16'h0000;
            next_so_bit = 1'b0;
        end else if (!pins.cs_n) begin
            if (sck_fall) begin
                next_shreg = {shreg[14:0], pins.si};
            end
            if (sck_rise) begin
                next_so_bit = txreg[15];
                next_txreg  = {txreg[14:0], 1'b0};
            end
        end
        if (cs_rise && mode == LSC_AWAKE) begin
            case (shreg[LSC_ADDR_MSB:LSC_ADDR_LSB])
                LSC_A_CTRL:  next_ctrl  = shreg[11:0];
                LSC_A_SENSE: next_sense = shreg[11:0];
                LSC_A_DUTY:  next_duty[shreg[9:8]] = shreg[7:0];
                LSC_A_FAULT: next_flt   = hw_fault_i; // clear latched faults
                default:     next_ctrl  = ctrl;
            endcase
        end
        if (!clk_check || dim_tick) begin
            next_clkmon = 32'h0000_0000;
        end else if (clkmon < CLK_TIMEOUT) begin
            next_clkmon = clkmon + 32'h0000_0001;
        end
        next_clkfail = clk_check && (clkmon >= CLK_TIMEOUT);
        if (pins.rst_n && !rstn_q) begin
            next_wdog_run = 1'b1;
            next_wdog     = 32'h0000_0000;
            next_wexp     = 1'b0;
        end else if (wdog_run) begin
            if (cs_rise) begin
                next_wdog = 32'h0000_0000;
            end else if (wdog >= WDOG_CYC - 1) begin
                next_wexp = 1'b1;
            end else begin
                next_wdog = wdog + 32'h0000_0001;
            end
        end
        if (!pins.rst_n) begin
            next_mode     = LSC_SLEEP;
            next_ctrl     = LSC_CTRL_RST;
            next_sense    = LSC_SNS_RST;
            next_flt      = 4'h0;
            next_wdog_run = 1'b0;
            for (int i = 0; i < LSC_NCH; i++) next_duty[i] = LSC_DUTY_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode    <= LSC_SLEEP;
            ctrl    <= LSC_CTRL_RST;
            sense   <= LSC_SNS_RST;
            for (int i = 0; i < LSC_NCH; i++) duty[i] <= LSC_DUTY_RST;
            shreg   <= 16'h0000;
            txreg   <= 16'h0000;
            so_bit  <= 1'b0;
            cs_q    <= 1'b1;
            sck_q   <= 1'b0;
            in0_q   <= 1'b0;
            // idle high, so leaving rst_i is no false rising edge
            rstn_q  <= 1'b1;
            flt     <= 4'h0;
            wdog    <= 32'h0000_0000;
            wdog_run <= 1'b0;
            wdog_expired_o <= 1'b0;
            clkmon  <= 32'h0000_0000;
            dim_clk_fail_o <= 1'b0;
        end else begin
            mode    <= next_mode;
            ctrl    <= next_ctrl;
            sense   <= next_sense;
            duty    <= next_duty;
            shreg   <= next_shreg;
            txreg   <= next_txreg;
            so_bit  <= next_so_bit;
            cs_q    <= next_cs_q;
            sck_q   <= next_sck_q;
            in0_q   <= next_in0_q;
            rstn_q  <= next_rstn_q;
            flt     <= next_flt;
            wdog    <= next_wdog;
            wdog_run <= next_wdog_run;
            wdog_expired_o <= next_wexp;
            clkmon  <= next_clkmon;
            dim_clk_fail_o <= next_clkfail;
        end
    end

    // with dimming on, outputs follow the dimmers, so a clock on input zero never reaches an output
    always_comb begin
        for (int i = 0; i < LSC_NCH; i++) begin
            if (mode != LSC_AWAKE) begin
                power_switch_out_o[i] = 1'b0;
            end else if (ctrl[LSC_CTRL_DIM_EN]) begin
                power_switch_out_o[i] = dim_on[i];
            end else begin
                power_switch_out_o[i] = pins.direct_ctl[i];
            end
        end
    end

    assign awake_o                = (mode == LSC_AWAKE);
    assign wdog_run_o             = wdog_run;
    assign pins.so                = so_bit;
    assign pins.so_oe_n           = pins.cs_n;
    assign pins.fault_flag_n_oe_n = ~(|flt);
    assign pins.sense_hiz         = sense[LSC_SNS_HIZ];
    assign pins.sense_temp        = sense[LSC_SNS_TEMP];
    assign pins.sense_ch          = sense[1:0];
endmodule // lsc_device

// >>> core/lsc_host.sv
// host end: wishbone controlled reset, wake, direct pins and serial master
module lsc_host
    import lsc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o,
    lsc_if.host              pins
);
    typedef enum logic [3:0] {
        LSC_IDLE = 4'b0001, LSC_RSTL = 4'b0010, LSC_ENBL = 4'b0100, LSC_SHFT = 4'b1000
    } lsc_hst_t;

    lsc_hst_t    st, next_st;
    logic [15:0] tx, next_tx, rx, next_rx;
    logic [9:0]  cnt, next_cnt;
    logic [5:0]  edges, next_edges;
    logic [4:0]  pinreg, next_pinreg;
    logic [1:0]  stat, next_stat, en, next_en;
    logic        ack, next_ack, sck, next_sck, csn, next_csn, rstn, next_rstn;

    wire req = cyc_i & stb_i & ~ack;
    // writes commit at the edge where the master sees ack high
    wire acc = cyc_i & stb_i & ack;
    wire wr  = acc & we_i & sel_i[0];
    wire ev_fault = ~pins.fault_flag_n_oe_n;

    always_comb begin
        next_st = st; next_tx = tx; next_rx = rx; next_cnt = cnt; next_edges = edges;
        next_pinreg = pinreg; next_en = en; next_ack = req;
        next_sck = sck; next_csn = csn; next_rstn = rstn;
        next_stat = stat;
        if (wr && adr_i == LSC_R_PINS) next_pinreg = dat_i[4:0];
        if (wr && adr_i == LSC_R_IRQ_CLR) next_stat = next_stat & ~dat_i[1:0];
        // event applied after the clear so that set wins
        next_stat = next_stat | {ev_fault, 1'b0};
        if (acc && we_i && sel_i[1] && adr_i == LSC_R_RX) next_en = dat_i[9:8];
        case (st)
            LSC_IDLE: if (wr && adr_i == LSC_R_CMD) begin
                if (dat_i[16]) begin
                    next_rstn = 1'b0; next_cnt = 10'(LSC_RST_LOW_CYC); next_st = LSC_RSTL;
                end else begin
                    next_tx = dat_i[15:0]; next_csn = 1'b0; next_edges = 6'd32;
                    next_cnt = 10'(LSC_SCK_HALF_CYC); next_st = LSC_SHFT;
                end
            end
            LSC_RSTL: if (cnt == 10'd0) begin
                next_rstn = 1'b1; next_cnt = 10'(LSC_RST_TO_CS_CYC); next_st = LSC_ENBL;
            end else next_cnt = cnt - 10'd1;
            LSC_ENBL: if (cnt == 10'd0) next_st = LSC_IDLE; else next_cnt = cnt - 10'd1;
            LSC_SHFT: if (cnt != 10'd0) next_cnt = cnt - 10'd1;
            else if (edges == 6'd0) begin
                next_csn = 1'b1; next_st = LSC_IDLE; next_stat[LSC_EV_DONE] = 1'b1;
            end else begin
                next_cnt = 10'(LSC_SCK_HALF_CYC); next_edges = edges - 6'd1; next_sck = ~sck;
                // si moves on the rising clock so it stands across the sampling fall
                if (sck) begin
                    next_rx = {rx[14:0], pins.so};
                end else if (edges != 6'd32) begin
                    next_tx = {tx[14:0], 1'b0};
                end
            end
            default: next_st = LSC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= LSC_IDLE; tx <= 16'h0000; rx <= 16'h0000; cnt <= 10'd0; edges <= 6'd0;
            pinreg <= 5'h00; stat <= 2'b00; en <= 2'b00; ack <= 1'b0;
            sck <= 1'b0; csn <= 1'b1; rstn <= 1'b1;
        end else begin
            st <= next_st; tx <= next_tx; rx <= next_rx; cnt <= next_cnt; edges <= next_edges;
            pinreg <= next_pinreg; stat <= next_stat; en <= next_en; ack <= next_ack;
            sck <= next_sck; csn <= next_csn; rstn <= next_rstn;
        end
    end

    always_comb begin
        case (adr_i)
            LSC_R_CMD:      dat_o = {31'h0000_0000, st != LSC_IDLE};
            LSC_R_RX:       dat_o = {22'h00_0000, en, 8'h00} | {16'h0000, rx};
            LSC_R_PINS:     dat_o = {27'h000_0000, pinreg};
            LSC_R_IRQ_STAT: dat_o = {30'h0000_0000, stat};
            default:        dat_o = 32'h0000_0000;
        endcase
    end

    assign ack_o           = ack;
    assign irq_o           = |(stat & en);
    assign pins.rst_n      = rstn;
    assign pins.cs_n       = csn;
    assign pins.sclk       = sck;
    assign pins.si         = tx[15];
    assign pins.wake       = pinreg[4];
    assign pins.direct_ctl = pinreg[3:0];
endmodule // lsc_host

// >>> dv/lsc_assertions.sv
// concurrent checks on the pins between host and lamp switch
module lsc_assertions
    import lsc_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       rst_n,
    input wire logic       wake,
    input wire logic [3:0] direct_ctl,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       fault_flag_n_oe_n,
    input wire logic       sense_hiz,
    input wire logic       sense_temp,
    input wire logic [1:0] sense_ch,
    input wire logic [3:0] hw_fault_i,
    input wire logic       awake_o,
    input wire logic       wdog_run_o
);
    logic [9:0] low_cnt;
    logic [9:0] hi_cnt;
    logic [4:0] fall_cnt;
    logic       sclk_q;
    // hi_cnt saturates so a long idle never wraps into a false short gap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt  <= '0;
            hi_cnt   <= '1;
            fall_cnt <= '0;
            sclk_q   <= 1'b0;
        end else begin
            sclk_q   <= sclk;
            low_cnt  <= rst_n ? 10'h000 : low_cnt + 10'h001;
            hi_cnt   <= !rst_n ? 10'h000 : (hi_cnt == 10'h3FF ? hi_cnt : hi_cnt + 10'h001);
            fall_cnt <= cs_n ? 5'h00 : fall_cnt + 5'(sclk_q & !sclk);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_half;
        $stable(sclk)[*3];
    endsequence
    sequence s_pin_rst;
        (!rst_n)[*4];
    endsequence
    sequence s_quiet_rst;
        (!rst_n && hw_fault_i == 4'h0)[*4];
    endsequence
    sel_clk_low_a: assert property ($changed(cs_n) |-> !sclk)
        else $error("select moved with serial clock high");
    frame_len_a: assert property ($rose(cs_n) |-> fall_cnt == LSC_WORD_BITS)
        else $error("frame without sixteen clock falls");
    sck_rate_a: assert property ($changed(sclk) |=> s_half)
        else $error("serial clock half period too short");
    rst_width_a: assert property ($rose(rst_n) |-> low_cnt >= LSC_RST_LOW_CYC)
        else $error("reset pin pulse too short");
    rst_to_sel_a: assert property ($fell(cs_n) |-> hi_cnt >= LSC_RST_TO_CS_CYC)
        else $error("select too soon after reset pin release");
    pin_rst_clr_a: assert property (s_pin_rst |-> sense_hiz && !sense_temp && sense_ch == 2'b00)
        else $error("reset pin left sense setting");
    flag_release_a: assert property (s_quiet_rst |-> fault_flag_n_oe_n)
        else $error("fault pin held after reset without fault");
    wdog_start_a: assert property ($rose(rst_n) |-> ##[1:4] wdog_run_o)
        else $error("watchdog not started by reset pin rise");
    wake_pin_a: assert property ($rose(wake) && rst_n |-> ##[1:4] awake_o)
        else $error("wake pin did not wake");
    direct_wake_a: assert property ($rose(|direct_ctl) && rst_n |-> ##[1:4] awake_o)
        else $error("direct input did not wake");
    fault_low_a: assert property ($rose(|hw_fault_i) && rst_n |-> ##[1:4] !fault_flag_n_oe_n)
        else $error("fault pin not pulled low on fault");
endmodule // lsc_assertions

// >>> dv/tb_top.sv
// self-checking bench: host and lamp switch joined by their pins
module tb_top
    import lsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sclk_q = 1'b0, cs_q = 1'b1;
    logic [3:0]  adr = 4'h0, sel = 4'h0, hw_fault = 4'h0, pso, v;
    logic [31:0] dwr = '0, dat_o, q, mm, ee;
    logic        ack_o, irq_o, awake, wdog_run, clk_fail, wexp;
    logic [15:0] wd = '0;
    logic [31:0] exp_rd[$], exp_msk[$];
    logic [15:0] exp_wd[$];
    int          err_total = 0, checked = 0;
    lsc_if       pins();
    lsc_host u_lsc_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dwr), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .pins(pins.host));
    // short watchdog and clock timeout keep the run brief
    lsc_device #(.WDOG_CYC(100), .CLK_TIMEOUT(50)) u_lsc_device (.clk_i(clk_i), .rst_i(rst_i),
        .pins(pins.dev), .hw_fault_i(hw_fault), .power_switch_out_o(pso), .awake_o(awake),
        .wdog_run_o(wdog_run), .wdog_expired_o(wexp), .dim_clk_fail_o(clk_fail));
    lsc_assertions u_lsc_assertions (.clk_i(clk_i), .rst_i(rst_i), .rst_n(pins.rst_n), .wake(pins.wake),
        .direct_ctl(pins.direct_ctl), .cs_n(pins.cs_n), .sclk(pins.sclk),
        .fault_flag_n_oe_n(pins.fault_flag_n_oe_n), .sense_hiz(pins.sense_hiz),
        .sense_temp(pins.sense_temp), .sense_ch(pins.sense_ch), .hw_fault_i(hw_fault),
        .awake_o(awake), .wdog_run_o(wdog_run));
    initial forever #10 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic timeout();
        err_total++;
        report_and_stop();
    endtask
    // one classic cycle; a read notes its masked expectation first
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        if (!w) exp_msk.push_back(m);
        if (!w) exp_rd.push_back(e);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= s;
        dwr <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 100);
        if (n >= 100) timeout();
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, LSC_R_CMD, 4'hF, '0, '0, '0);
            n++;
        end while (q[0] !== 1'b0 && n < 1000);
        if (n >= 1000) timeout();
    endtask
    task automatic send(input logic [15:0] w);
        exp_wd.push_back(w);
        wb(1'b1, LSC_R_CMD, 4'hF, {16'h0000, w}, '0, '0);
        idle();
    endtask
    task automatic pins_wr(input logic [31:0] d);
        wb(1'b1, LSC_R_PINS, 4'hF, d, '0, '0);
        repeat (6) @(posedge clk_i);
    endtask
    task automatic prst();
        pins_wr(32'h0);
        wb(1'b1, LSC_R_CMD, 4'hF, 32'h0001_0000, '0, '0);
        idle();
    endtask
    // results: read data on ack, and each frame's word seen on the wire
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0 && exp_rd.size() > 0) begin
            mm = exp_msk.pop_front();
            ee = exp_rd.pop_front();
            chk(dat_o & mm, ee & mm);
        end
        if (pins.cs_n === 1'b0 && sclk_q === 1'b1 && pins.sclk === 1'b0) wd = {wd[14:0], pins.si};
        if (cs_q === 1'b0 && pins.cs_n === 1'b1 && exp_wd.size() > 0) chk(32'(wd), 32'(exp_wd.pop_front()));
        sclk_q = pins.sclk;
        cs_q = pins.cs_n;
    end
    initial begin
        void'($urandom(32'h96f4));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, LSC_R_IRQ_STAT, 4'hF, '0, 32'h3, 32'h0);
        chk(32'(irq_o), 32'h0);
        chk(32'({wdog_run, wexp}), 32'h0);
        prst();
        chk(32'(wdog_run), 32'h1);
        chk(32'(wexp), 32'h1);
        chk(32'(pins.sense_hiz), 32'h1);
        v = 4'($urandom_range(15, 1));
        pins_wr(32'(v));
        chk(32'(awake), 32'h1);
        chk(32'(pso), 32'(v));
        prst();
        pins_wr(32'h10);
        chk(32'(awake), 32'h1);
        for (int i = 0; i < 4; i++) begin
            pins_wr(32'h10 | (32'h1 << i));
            chk(32'(pso), 32'h1 << i);
        end
        pins_wr(32'h10);
        wb(1'b1, LSC_R_RX, 4'b0010, 32'h0000_0300, '0, '0);
        wb(1'b1, LSC_R_IRQ_CLR, 4'hF, 32'h3, '0, '0);
        for (int i = 0; i < 4; i++) begin
            send({LSC_A_SENSE, 10'h000, 2'(i)});
            chk(32'({pins.sense_hiz, pins.sense_temp, pins.sense_ch}), 32'(i));
        end
        send({LSC_A_SENSE, 12'h004});
        chk(32'({pins.sense_hiz, pins.sense_temp, pins.sense_ch}), 32'h4);
        send({LSC_A_SENSE, 12'h008});
        chk(32'(pins.sense_hiz), 32'h1);
        chk(32'(irq_o), 32'h1);
        wb(1'b0, LSC_R_IRQ_STAT, 4'hF, '0, 32'h1, 32'h1);
        wb(1'b1, LSC_R_IRQ_CLR, 4'hF, 32'h1, '0, '0);
        wb(1'b0, LSC_R_IRQ_STAT, 4'hF, '0, 32'h1, 32'h0);
        chk(32'(irq_o), 32'h0);
        wb(1'b1, LSC_R_RX, 4'b0010, 32'h0000_0200, '0, '0);
        send({LSC_A_SENSE, 12'h008});
        chk(32'(irq_o), 32'h0);
        wb(1'b0, LSC_R_IRQ_STAT, 4'hF, '0, 32'h1, 32'h1);
        v = 4'($urandom_range(15, 1));
        hw_fault <= v;
        repeat (6) @(posedge clk_i);
        chk(32'(pins.fault_flag_n_oe_n), 32'h0);
        chk(32'(irq_o), 32'h1);
        wb(1'b0, LSC_R_IRQ_STAT, 4'hF, '0, 32'h2, 32'h2);
        // address zero holds no register; the frame only fetches fault detail
        send({4'h0, 12'h000});
        wb(1'b0, LSC_R_RX, 4'hF, '0, 32'h0000_F0FF, 32'(v));
        hw_fault <= 4'h0;
        send({LSC_A_FAULT, 12'h000});
        chk(32'(pins.fault_flag_n_oe_n), 32'h1);
        prst();
        chk(32'(pins.fault_flag_n_oe_n), 32'h1);
        pins_wr(32'h10);
        // internal clock first: the detector must stay quiet
        send({LSC_A_CTRL, 12'h003});
        send({LSC_A_DUTY, 2'b00, 2'b00, 8'hFF});
        send({LSC_A_DUTY, 2'b00, 2'b01, 8'h00});
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_i);
            chk(32'(pso[1:0]), 32'h1);
        end
        chk(32'(clk_fail), 32'h0);
        send({LSC_A_CTRL, 12'h001});
        for (int i = 0; i < 12; i++) pins_wr(32'h10 | 32'(i & 1));
        chk(32'(clk_fail), 32'h0);
        repeat (120) @(posedge clk_i);
        chk(32'(clk_fail), 32'h1);
        wb(1'b0, 4'h2, 4'hF, '0, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(1'b0, LSC_R_RX, 4'hF, '0, 32'h0000_FFFF, 32'h0000_0200);
        report_and_stop();
    end
endmodule // tb_top
